// file: design/pms_pkg.sv
/*
  pms_pkg: register map, field layouts, reset values, states and carriers
  of the power mode and clock startup block.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package pms_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned EXTENDED_INTERRUPT_LINES_W = 16;
  localparam int unsigned SYNC_W = 26;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CLK      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;

  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CLK_W  = 8;
  localparam int unsigned IRQ_W  = 2;
  localparam int unsigned IRQ_CFAIL_BIT = 0;
  localparam int unsigned IRQ_WAKE_BIT  = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LP_SLEEP   = 2'b00,
    LP_STOP    = 2'b01,
    LP_STANDBY = 2'b10
  } pms_lp_type;

  typedef enum logic [2:0] {
    PS_HOLD    = 3'b000,
    PS_RUN     = 3'b001,
    PS_SLEEP   = 3'b010,
    PS_STOP    = 3'b011,
    PS_STANDBY = 3'b100
  } pms_state_type;

  typedef enum logic [1:0] {
    BOOT_FLASH  = 2'b00,
    BOOT_SYSMEM = 2'b01,
    BOOT_SRAM   = 2'b10
  } pms_boot_type;

  // CTRL: [1:0] mode, [2] low-power regulator in stop, [3] ext osc, [4] pll
  typedef struct packed {
    logic       pll_en;
    logic       ext_osc_en;
    logic       lp_reg_sel;
    logic [1:0] mode;
  } pms_ctrl_type;

  // CLK: [0] external source, [4:1] high-speed bus div, [7:5] periph div
  typedef struct packed {
    logic [2:0] apb_div;
    logic [3:0] ahb_div;
    logic       sel_ext;
  } pms_clk_type;

  typedef struct packed {
    logic         sys_reset;
    logic         core_halt;
    logic         core_clk_en;
    logic         reg_en;
    logic         reg_lp;
    logic         int_osc_en;
    logic         ext_osc_en;
    logic         pll_en;
    logic         lowclk_en;
    logic         sel_ext;
    logic [3:0]   ahb_div;
    logic [2:0]   apb_div;
    pms_boot_type boot;
  } pms_out_type;

  localparam pms_ctrl_type CTRL_RST = '0;
  localparam pms_clk_type  CLK_RST  = '0;
  localparam pms_out_type  OUT_RST  = '{sys_reset: 1'b1, core_halt: 1'b1,
    core_clk_en: 1'b0, reg_en: 1'b1, reg_lp: 1'b0, int_osc_en: 1'b1,
    ext_osc_en: 1'b0, pll_en: 1'b0, lowclk_en: 1'b1, sel_ext: 1'b0,
    ahb_div: 4'h0, apb_div: 3'h0, boot: BOOT_FLASH};

endpackage

// file: design/pms_power_seq.sv
/*
  pms_power_seq: reset hold, boot selection, system clock selection with
  failover, bus prescalers and Sleep/Stop/Standby sequencing, with an
  AXI4-Lite register slave and one level interrupt.
  Assumes pin and other-domain inputs are asynchronous levels; CORE_WFI
  and PERIPH_IRQ come from logic on CORE_CLK.
*/
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module pms_power_seq
  import pms_pkg::*;
(
  input  wire logic                CORE_CLK,
  input  wire logic                RESET,
  input  wire logic [ADDR_W-1:0]   AWADDR,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [DATA_W-1:0]   WDATA,
  input  wire logic [3:0]          WSTRB,
  input  wire logic                WVALID,
  output logic                     WREADY,
  output logic [1:0]               BRESP,
  output logic                     BVALID,
  input  wire logic                BREADY,
  input  wire logic [ADDR_W-1:0]   ARADDR,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  output logic [DATA_W-1:0]        RDATA,
  output logic [1:0]               RRESP,
  output logic                     RVALID,
  input  wire logic                RREADY,
  input  wire logic                VDD_LOW,
  input  wire logic                VDDA_LOW,
  input  wire logic                VDDA_MON_OFF,
  input  wire logic                BOOT_PIN,
  input  wire logic                BOOT_SEL_OPT,
  input  wire logic                EXTERNAL_RESET_PIN_N,
  input  wire logic                INDEPENDENT_WATCHDOG_RST,
  input  wire logic                WAKEUP_PIN,
  input  wire logic                RTC_EVENT,
  input  wire logic                EXT_CLK_FAIL,
  input  wire logic [EXTENDED_INTERRUPT_LINES_W-1:0]   EXTENDED_INTERRUPT_LINES,
  input  wire logic                CORE_WFI,
  input  wire logic                PERIPH_IRQ,
  output logic                     SYS_RESET,
  output logic                     CORE_HALT,
  output logic                     CORE_CLK_EN,
  output logic                     REG_EN,
  output logic                     LOW_POWER_REGULATOR_MODE,
  output logic                     INTERNAL_FAST_RC_OSC_EN,
  output logic                     EXTERNAL_CRYSTAL_OSC_EN,
  output logic                     PLL_EN,
  output logic                     LOWCLK_EN,
  output logic                     SYSCLK_EXT,
  output logic [3:0]               AHB_DIV,
  output logic [2:0]               APB_DIV,
  output logic [1:0]               BOOT_SRC,
  output logic                     IRQ
);

  pms_state_type     state;
  pms_state_type     next_state;
  pms_state_type     lp_target;
  pms_ctrl_type      ctrl;
  pms_clk_type       clk;
  pms_out_type       outs;
  pms_out_type       next_out;
  pms_boot_type      boot_src;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_en;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic [SYNC_W-1:0] sync_q;
  logic              wakeup_pin_d;
  logic [1:0]        sync_vld;

  // synchronised pin levels
  pms_sync #(.WIDTH(SYNC_W)) u_sync (
    .CORE_CLK (CORE_CLK),
    .RESET    (RESET),
    .d        ({VDD_LOW, VDDA_LOW, VDDA_MON_OFF, BOOT_PIN, BOOT_SEL_OPT,
                EXTERNAL_RESET_PIN_N, INDEPENDENT_WATCHDOG_RST, WAKEUP_PIN,
                RTC_EVENT, EXT_CLK_FAIL, EXTENDED_INTERRUPT_LINES}),
    .q        (sync_q)
  );

  wire              vdd_low_s  = sync_q[25];
  wire              vdda_low_s = sync_q[24];
  wire              mon_off_s  = sync_q[23];
  wire              boot_pin_s = sync_q[22];
  wire              boot_opt_s = sync_q[21];
  wire              external_reset_pin_s     = sync_q[20];
  wire              wdog_s     = sync_q[19];
  wire              wakeup_pin_s     = sync_q[18];
  wire              rtc_s      = sync_q[17];
  wire              fail_s     = sync_q[16];
  wire [EXTENDED_INTERRUPT_LINES_W-1:0] extended_interrupt_lines_s     = sync_q[EXTENDED_INTERRUPT_LINES_W-1:0];

  wire supply_low = vdd_low_s || (vdda_low_s && !mon_off_s);
  wire soft_rst   = (state == PS_HOLD);
  wire run_sleep  = (state == PS_RUN) || (state == PS_SLEEP);

  wire extended_interrupt_lines_any   = (|extended_interrupt_lines_s) || rtc_s;
  wire wake_sleep = PERIPH_IRQ || extended_interrupt_lines_any;
  wire wakeup_pin_rise  = wakeup_pin_s && !wakeup_pin_d;
  wire wake_stby  = !external_reset_pin_s || wdog_s || wakeup_pin_rise || rtc_s;

  wire cfail = clk.sel_ext && fail_s && !soft_rst;

  assign lp_target = (ctrl.mode == LP_STOP)    ? PS_STOP :
                     (ctrl.mode == LP_STANDBY) ? PS_STANDBY : PS_SLEEP;

  always_comb begin
    next_state = state;
    unique case (state)
      PS_HOLD:    if (!supply_low && sync_vld[1]) next_state = PS_RUN;
      PS_RUN:     if (CORE_WFI) next_state = lp_target;
      PS_SLEEP:   if (wake_sleep) next_state = PS_RUN;
      PS_STOP:    if (extended_interrupt_lines_any) next_state = PS_RUN;
      PS_STANDBY: if (wake_stby) next_state = PS_HOLD;
      default:    next_state = PS_HOLD;
    endcase
    if (supply_low) next_state = PS_HOLD;
  end

  // boot source decode
  wire [1:0] boot_pick = !boot_pin_s ? BOOT_FLASH :
                         boot_opt_s ? BOOT_SYSMEM : BOOT_SRAM;

  always_comb begin
    next_out             = OUT_RST;
    next_out.sys_reset   = soft_rst;
    next_out.core_halt   = (state != PS_RUN);
    next_out.core_clk_en = run_sleep;
    next_out.reg_en      = (state != PS_STANDBY);
    next_out.reg_lp      = (state == PS_STOP) && ctrl.lp_reg_sel;
    next_out.int_osc_en  = run_sleep || soft_rst;
    next_out.ext_osc_en  = run_sleep && ctrl.ext_osc_en;
    next_out.pll_en      = run_sleep && ctrl.pll_en;
    next_out.lowclk_en   = 1'b1;
    next_out.sel_ext     = clk.sel_ext && !soft_rst;
    next_out.ahb_div     = clk.ahb_div;
    next_out.apb_div     = clk.apb_div;
    next_out.boot        = boot_src;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state    <= PS_HOLD;
      outs     <= OUT_RST;
      wakeup_pin_d   <= 1'b0;
      sync_vld <= 2'b00;
    end else begin
      state    <= next_state;
      outs     <= next_out;
      wakeup_pin_d   <= wakeup_pin_s;
      sync_vld <= {sync_vld[0], 1'b1};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      boot_src <= BOOT_FLASH;
    end else if (soft_rst) begin
      boot_src <= pms_boot_type'(boot_pick);
    end
  end

  // register bus slave
  logic              aw_rdy;
  logic              w_rdy;
  logic              ar_rdy;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic              w_lane0;
  logic [DATA_W-1:0] rd_data;
  logic [1:0]        rd_resp;

  wire wr_fire = !aw_rdy && !w_rdy && !BVALID;
  wire [ADDR_W-1:0] wa = {aw_addr[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] ra = {ARADDR[ADDR_W-1:2], 2'b00};
  wire wa_hit = (wa == OFS_CTRL) || (wa == OFS_CLK) || (wa == OFS_STATUS) ||
                (wa == OFS_IRQ_STAT) || (wa == OFS_IRQ_CLR) || (wa == OFS_IRQ_EN);
  wire wr_en   = wr_fire && w_lane0;
  wire wr_ctrl = wr_en && (wa == OFS_CTRL);
  wire wr_clk  = wr_en && (wa == OFS_CLK);
  wire wr_clr  = wr_en && (wa == OFS_IRQ_CLR);
  wire wr_ien  = wr_en && (wa == OFS_IRQ_EN);

  always_comb begin
    rd_resp = RESP_OKAY;
    unique case (ra)
      OFS_CTRL:     rd_data = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
      OFS_CLK:      rd_data = {{(DATA_W-CLK_W){1'b0}}, clk};
      OFS_STATUS:   rd_data = {26'h0, outs.boot, outs.sel_ext, state};
      OFS_IRQ_STAT: rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_stat};
      OFS_IRQ_CLR:  rd_data = 32'h0;
      OFS_IRQ_EN:   rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_en};
      default: begin
        rd_data = 32'h0;
        rd_resp = RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      aw_rdy  <= 1'b1;
      w_rdy   <= 1'b1;
      aw_addr <= '0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= RESP_OKAY;
    end else begin
      if (AWVALID && aw_rdy) begin
        aw_rdy  <= 1'b0;
        aw_addr <= AWADDR;
      end
      if (WVALID && w_rdy) begin
        w_rdy   <= 1'b0;
        w_data  <= WDATA;
        w_lane0 <= WSTRB[0];
      end
      if (wr_fire) begin
        aw_rdy <= 1'b1;
        w_rdy  <= 1'b1;
        BVALID <= 1'b1;
        BRESP  <= wa_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ar_rdy <= 1'b1;
      RVALID <= 1'b0;
      RDATA  <= '0;
      RRESP  <= RESP_OKAY;
    end else if (ARVALID && ar_rdy) begin
      ar_rdy <= 1'b0;
      RVALID <= 1'b1;
      RDATA  <= rd_data;
      RRESP  <= rd_resp;
    end else if (RVALID && RREADY) begin
      ar_rdy <= 1'b1;
      RVALID <= 1'b0;
    end
  end

  assign AWREADY = aw_rdy;
  assign WREADY  = w_rdy;
  assign ARREADY = ar_rdy;

  always_ff @(posedge CORE_CLK) begin
    if (RESET || soft_rst) begin
      ctrl <= CTRL_RST;
      clk  <= CLK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pms_ctrl_type'(w_data[CTRL_W-1:0]);
      end
      if (wr_clk) begin
        clk <= pms_clk_type'(w_data[CLK_W-1:0]);
      end
      if (cfail) begin
        clk.sel_ext <= 1'b0;
      end
    end
  end

  assign irq_set = {(state == PS_SLEEP || state == PS_STOP) && next_state == PS_RUN,
                    cfail};
  assign irq_clr = wr_clr ? w_data[IRQ_W-1:0] : '0;

  always_ff @(posedge CORE_CLK) begin
    if (RESET || soft_rst) begin
      irq_stat <= '0;
      irq_en   <= '0;
      IRQ      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_ien) begin
        irq_en <= w_data[IRQ_W-1:0];
      end
      IRQ      <= |(irq_stat & irq_en);
    end
  end

  assign SYS_RESET                = outs.sys_reset;
  assign CORE_HALT                = outs.core_halt;
  assign CORE_CLK_EN              = outs.core_clk_en;
  assign REG_EN                   = outs.reg_en;
  assign LOW_POWER_REGULATOR_MODE = outs.reg_lp;
  assign INTERNAL_FAST_RC_OSC_EN  = outs.int_osc_en;
  assign EXTERNAL_CRYSTAL_OSC_EN  = outs.ext_osc_en;
  assign PLL_EN                   = outs.pll_en;
  assign LOWCLK_EN                = outs.lowclk_en;
  assign SYSCLK_EXT               = outs.sel_ext;
  assign AHB_DIV                  = outs.ahb_div;
  assign APB_DIV                  = outs.apb_div;
  assign BOOT_SRC                 = outs.boot;

  property p_sleep_core;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == PS_SLEEP) |=> CORE_HALT && CORE_CLK_EN;
  endproperty
  a_sleep_core: assert property (p_sleep_core)
    else $error("sleep did not halt core with clocks on");

  property p_stop_osc;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == PS_STOP) |=> !CORE_CLK_EN && !PLL_EN && !INTERNAL_FAST_RC_OSC_EN
                           && !EXTERNAL_CRYSTAL_OSC_EN && REG_EN;
  endproperty
  a_stop_osc: assert property (p_stop_osc)
    else $error("stop left a clock or oscillator on");

  property p_stop_reg;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == PS_STOP) |=> (LOW_POWER_REGULATOR_MODE == $past(ctrl.lp_reg_sel));
  endproperty
  a_stop_reg: assert property (p_stop_reg)
    else $error("stop regulator mode differs from selection");

  property p_stop_wake;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == PS_STOP && extended_interrupt_lines_any && !supply_low) |=> (state == PS_RUN) ##1 CORE_CLK_EN;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("stop not left on extended line");

  property p_stby_off;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == PS_STANDBY) |=> !REG_EN && !PLL_EN && !INTERNAL_FAST_RC_OSC_EN
                              && !EXTERNAL_CRYSTAL_OSC_EN && LOWCLK_EN;
  endproperty
  a_stby_off: assert property (p_stby_off)
    else $error("standby left regulator or oscillator on");

  property p_stby_exit;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == PS_STANDBY && wake_stby) |=> (state == PS_HOLD) ##1 SYS_RESET && !SYSCLK_EXT;
  endproperty
  a_stby_exit: assert property (p_stby_exit)
    else $error("standby exit did not reset");

  property p_cfail;
    @(posedge CORE_CLK) disable iff (RESET)
    (cfail && !supply_low) |=> !clk.sel_ext && irq_stat[IRQ_CFAIL_BIT] ##1 !SYSCLK_EXT;
  endproperty
  a_cfail: assert property (p_cfail)
    else $error("clock failure did not fall back");

  property p_cfail_irq;
    @(posedge CORE_CLK) disable iff (RESET)
    (irq_stat[IRQ_CFAIL_BIT] && irq_en[IRQ_CFAIL_BIT] && !soft_rst) |=> IRQ;
  endproperty
  a_cfail_irq: assert property (p_cfail_irq)
    else $error("enabled clock failure raised no interrupt");

  property p_run_reg;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == PS_RUN) |=> REG_EN && !LOW_POWER_REGULATOR_MODE && !SYS_RESET;
  endproperty
  a_run_reg: assert property (p_run_reg)
    else $error("run without main regulator");

  property p_supply_hold;
    @(posedge CORE_CLK) disable iff (RESET)
    supply_low |=> (state == PS_HOLD) ##1 SYS_RESET;
  endproperty
  a_supply_hold: assert property (p_supply_hold)
    else $error("low supply did not hold reset");

  property p_boot;
    @(posedge CORE_CLK) disable iff (RESET)
    (soft_rst && !boot_pin_s) |=> ##1 (BOOT_SRC == BOOT_FLASH);
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot pin low did not select flash");

endmodule

`default_nettype wire

// file: design/pms_sync.sv
/*
  pms_sync: two-stage synchroniser for a vector of slow pin levels.
  Assumes each bit is a level that holds for several clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module pms_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RESET,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// file: testbench/pms_core_model.sv
/*
  pms_core_model: stand-in for the processor core and the peripherals that
  ask for low-power entry and raise interrupts.
  Assumes commands from the bench arrive as levels on CORE_CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module pms_core_model (
  input  wire logic CORE_CLK,
  input  wire logic RESET,
  input  wire logic CORE_HALT,
  input  wire logic SYS_RESET,
  input  wire logic sleep_req,
  input  wire logic irq_req,
  output logic      CORE_WFI,
  output logic      PERIPH_IRQ
);
  always_ff @(posedge CORE_CLK) begin
    CORE_WFI   <= sleep_req && !RESET && !CORE_HALT && !SYS_RESET;
    PERIPH_IRQ <= irq_req && !RESET;
  end
endmodule

`default_nettype wire

// file: testbench/power_mode_and_clock_startup_bench.sv
/*
  power_mode_and_clock_startup_bench: self-checking bench of pms_power_seq.
  Assumes the package, the design and the core model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module power_mode_and_clock_startup_bench;
  import pms_pkg::*;
  logic        CORE_CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, CORE_WFI, PERIPH_IRQ;
  logic        VDD_LOW, VDDA_LOW, VDDA_MON_OFF, BOOT_PIN, BOOT_SEL_OPT;
  logic        EXTERNAL_RESET_PIN_N, INDEPENDENT_WATCHDOG_RST, WAKEUP_PIN;
  logic        RTC_EVENT, EXT_CLK_FAIL, SYS_RESET, CORE_HALT, CORE_CLK_EN, REG_EN;
  logic        LOW_POWER_REGULATOR_MODE, INTERNAL_FAST_RC_OSC_EN, PLL_EN, IRQ;
  logic        EXTERNAL_CRYSTAL_OSC_EN, LOWCLK_EN, SYSCLK_EXT, sleep_req, irq_req;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd, v;
  logic [3:0]  WSTRB, AHB_DIV;
  logic [2:0]  APB_DIV;
  logic [1:0]  BRESP, RRESP, BOOT_SRC, rs, bs;
  logic [15:0] EXTENDED_INTERRUPT_LINES;
  logic        lp;
  int          seed, miscompares, n_checks, k;

  pms_power_seq pms_power_seq_inst (.*);
  pms_core_model pms_core_model_inst (.*);

  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] exp_boot(input logic p, input logic o);
    return !p ? 32'h0 : (o ? 32'h1 : 32'h2);
  endfunction

  task automatic settle();
    repeat (10) @(posedge CORE_CLK);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (aw || w || !b) begin
      @(posedge CORE_CLK);
      if (!aw && !w && BVALID === 1'b1) begin
        b = 1'b1;
        bs = BRESP;
      end
      if (aw && AWREADY === 1'b1) begin
        aw = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w && WREADY === 1'b1) begin
        w = 1'b0;
        WVALID <= 1'b0;
      end
    end
    BREADY <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    ar = 1'b1;
    r = 1'b0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!r) begin
      @(posedge CORE_CLK);
      if (!ar && RVALID === 1'b1) begin
        r = 1'b1;
        rd = RDATA;
        rs = RRESP;
      end
      if (ar && ARREADY === 1'b1) begin
        ar = 1'b0;
        ARVALID <= 1'b0;
      end
    end
    RREADY <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic enter_lp(input logic [1:0] m, input logic l);
    axi_wr(OFS_CTRL, {27'h0, 2'b11, l, m});
    sleep_req <= 1'b1;
    @(posedge CORE_CLK);
    sleep_req <= 1'b0;
    settle();
  endtask

  initial begin
    repeat (20000) @(posedge CORE_CLK);
    miscompares++;
    report_and_stop();
  end

  initial begin
    seed = 25;
    miscompares = 0;
    n_checks = 0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, sleep_req, irq_req} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {VDD_LOW, VDDA_LOW, VDDA_MON_OFF, INDEPENDENT_WATCHDOG_RST} = '0;
    {WAKEUP_PIN, RTC_EVENT, EXT_CLK_FAIL} = '0;
    EXTENDED_INTERRUPT_LINES = '0;
    EXTERNAL_RESET_PIN_N = 1'b1;
    BOOT_PIN = 1'($random(seed));
    BOOT_SEL_OPT = 1'($random(seed));
    RESET = 1'b1;
    repeat (20) @(posedge CORE_CLK);
    RESET <= 1'b0;
    settle();
    chk(32'({SYS_RESET, SYSCLK_EXT, LOW_POWER_REGULATOR_MODE}), 32'h0);
    chk(32'({REG_EN, INTERNAL_FAST_RC_OSC_EN, LOWCLK_EN}), 32'h7);
    chk(32'(BOOT_SRC), exp_boot(BOOT_PIN, BOOT_SEL_OPT));
    axi_rd(OFS_STATUS);
    chk(rd, 32'h1 | (exp_boot(BOOT_PIN, BOOT_SEL_OPT) << 4));
    for (int i = 0; i < 4; i++) begin
      axi_rd(i == 0 ? OFS_CTRL : i == 1 ? OFS_CLK : i == 2 ? OFS_IRQ_STAT : OFS_IRQ_EN);
      chk(rd, 32'h0);
    end
    axi_rd(8'h18);
    chk({rd[29:0], rs}, 32'(RESP_SLVERR));
    axi_wr(8'h18, 32'h0);
    chk(32'(bs), 32'(RESP_SLVERR));
    // every prescaler code is software's choice; the block applies no limit
    v = {24'h0, 7'($random(seed)), 1'b1};
    axi_wr(OFS_CLK, v);
    chk(32'(bs), 32'(RESP_OKAY));
    settle();
    chk(32'({APB_DIV, AHB_DIV, SYSCLK_EXT}), v);
    EXT_CLK_FAIL <= 1'b1;
    settle();
    chk(32'({SYSCLK_EXT, IRQ}), 32'h0);
    axi_rd(OFS_IRQ_STAT);
    chk(rd & 32'h1, 32'h1);
    EXT_CLK_FAIL <= 1'b0;
    axi_wr(OFS_IRQ_EN, 32'h1);
    settle();
    chk(32'(IRQ), 32'h1);
    axi_wr(OFS_IRQ_CLR, 32'h1);
    settle();
    chk(32'(IRQ), 32'h0);
    for (int j = 0; j < 2; j++) begin
      enter_lp({j[0], j[0]}, 1'b0);
      chk(32'({CORE_HALT, CORE_CLK_EN, PLL_EN}), 32'h7);
      irq_req <= 1'b1;
      settle();
      chk(32'(CORE_HALT), 32'h0);
      irq_req <= 1'b0;
    end
    for (int j = 0; j < 2; j++) begin
      axi_wr(OFS_IRQ_CLR, 32'h2);
      lp = 1'($random(seed));
      k = $random(seed);
      enter_lp(2'b01, lp);
      chk(32'({CORE_HALT, CORE_CLK_EN, PLL_EN, EXTERNAL_CRYSTAL_OSC_EN}), 32'h8);
      chk(32'({INTERNAL_FAST_RC_OSC_EN, LOWCLK_EN, LOW_POWER_REGULATOR_MODE}), {30'h1, lp});
      if (j == 0) EXTENDED_INTERRUPT_LINES <= 16'h1 << k[3:0];
      else RTC_EVENT <= 1'b1;
      settle();
      chk(32'({CORE_HALT, LOW_POWER_REGULATOR_MODE}), 32'h0);
      EXTENDED_INTERRUPT_LINES <= '0;
      RTC_EVENT <= 1'b0;
      axi_rd(OFS_IRQ_STAT);
      chk(rd & 32'h2, 32'h2);
    end
    for (int j = 0; j < 4; j++) begin
      axi_wr(OFS_CLK, 32'h1);
      enter_lp(2'b10, 1'b0);
      chk(32'({REG_EN, PLL_EN, EXTERNAL_CRYSTAL_OSC_EN, INTERNAL_FAST_RC_OSC_EN}), 32'h0);
      chk(32'(LOWCLK_EN), 32'h1);
      BOOT_PIN <= 1'($random(seed));
      BOOT_SEL_OPT <= 1'($random(seed));
      case (j)
        0: EXTERNAL_RESET_PIN_N <= 1'b0;
        1: INDEPENDENT_WATCHDOG_RST <= 1'b1;
        2: WAKEUP_PIN <= 1'b1;
        default: RTC_EVENT <= 1'b1;
      endcase
      repeat (3) @(posedge CORE_CLK);
      EXTERNAL_RESET_PIN_N <= 1'b1;
      {INDEPENDENT_WATCHDOG_RST, WAKEUP_PIN, RTC_EVENT} <= '0;
      settle();
      chk(32'({SYS_RESET, CORE_HALT, SYSCLK_EXT, REG_EN}), 32'h1);
      chk(32'(BOOT_SRC), exp_boot(BOOT_PIN, BOOT_SEL_OPT));
      axi_rd(OFS_CTRL);
      chk(rd, 32'h0);
    end
    VDD_LOW <= 1'b1;
    settle();
    chk(32'(SYS_RESET), 32'h1);
    VDD_LOW <= 1'b0;
    settle();
    chk(32'(SYS_RESET), 32'h0);
    VDDA_MON_OFF <= 1'b1;
    VDDA_LOW <= 1'b1;
    settle();
    chk(32'(SYS_RESET), 32'h0);
    VDDA_MON_OFF <= 1'b0;
    settle();
    chk(32'(SYS_RESET), 32'h1);
    VDDA_LOW <= 1'b0;
    settle();
    chk(32'(SYS_RESET), 32'h0);
    report_and_stop();
  end
endmodule

`default_nettype wire
